// ===== ldram_regs.vh
`ifndef LDRAM_REGS_VH
`define LDRAM_REGS_VH
`define LDRAM_ADDR_CTRL 32'h00000000
`define LDRAM_ADDR_STATUS 32'h00000004
`define LDRAM_ADDR_ADDR 32'h00000008
`define LDRAM_ADDR_WDATA 32'h0000000C
`define LDRAM_ADDR_RDATA 32'h00000010
`define LDRAM_ORG_DUAL16 2'h0
`define LDRAM_ORG_WIDE32 2'h1
`define LDRAM_ORG_DPORT 2'h2
`define LDRAM_ORG_MIXED 2'h3
`define LDRAM_CTRL_ORG_LSB 0
`define LDRAM_CTRL_LEVEL_BIT 2
`define LDRAM_CTRL_EDGE_BIT 3
`define LDRAM_CTRL_RESET 32'h00000000
`define LDRAM_RESP_OKAY 2'h0
`define LDRAM_RESP_SLVERR 2'h2
`define LDRAM_DEPTH 16
`endif

// ===== ldram_table.v
`timescale 1ns/1ps
module ldram_table (
    aclk,
    clk_neg,
    level_mode,
    wr_en,
    wr_addr,
    wr_data,
    rd_addr_a,
    rd_addr_b,
    rd_data_a,
    rd_data_b
);
    input wire aclk;
    input wire clk_neg;
    input wire level_mode;
    input wire wr_en;
    input wire [3:0] wr_addr;
    input wire wr_data;
    input wire [3:0] rd_addr_a;
    input wire [3:0] rd_addr_b;
    output wire rd_data_a;
    output wire rd_data_b;

    reg [15:0] mem_r;
    reg dly_en_r;
    reg [3:0] dly_addr_r;
    reg dly_data_r;

    // With one clock there is no second edge to write on, so the other
    // edge choice lands an edge-mode write one cycle later instead.
    always @(posedge aclk) begin
        dly_en_r <= wr_en & ~level_mode & clk_neg;
        dly_addr_r <= wr_addr;
        dly_data_r <= wr_data;
        if (dly_en_r) begin
            mem_r[dly_addr_r] <= dly_data_r;
        end
        // Level mode writes every cycle the strobe is held high.
        if (wr_en & (level_mode | ~clk_neg)) begin
            mem_r[wr_addr] <= wr_data;
        end
    end

    // Reads never wait for a clock.
    assign rd_data_a = mem_r[rd_addr_a];
    assign rd_data_b = mem_r[rd_addr_b];
endmodule

// ===== ldram_top.v
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ldram_regs.vh"
module ldram_top (
    aclk,
    aresetn,
    awaddr,
    awvalid,
    awready,
    wdata,
    wstrb,
    wvalid,
    wready,
    bresp,
    bvalid,
    bready,
    araddr,
    arvalid,
    arready,
    rdata,
    rresp,
    rvalid,
    rready,
    logic_in,
    logic_out
);
    input wire aclk;
    input wire aresetn;
    input wire [31:0] awaddr;
    input wire awvalid;
    output wire awready;
    input wire [31:0] wdata;
    input wire [3:0] wstrb;
    input wire wvalid;
    output wire wready;
    output reg [1:0] bresp;
    output reg bvalid;
    input wire bready;
    input wire [31:0] araddr;
    input wire arvalid;
    output wire arready;
    output reg [31:0] rdata;
    output reg [1:0] rresp;
    output reg rvalid;
    input wire rready;
    input wire [4:0] logic_in;
    output reg logic_out;

    reg [31:0] ctrl_r;
    reg [31:0] addr_r;
    reg [31:0] awaddr_r;
    reg aw_have_r;
    reg [31:0] wdata_r;
    reg w_have_r;
    reg [15:0] func_r;
    reg wr_f_r;
    reg wr_g_r;
    reg wr_data_f_r;
    reg wr_data_g_r;
    wire [1:0] org;
    wire level_mode;
    wire clk_neg;
    wire rd_f_a;
    wire rd_f_b;
    wire rd_g_a;
    wire rd_g_b;
    wire do_write;
    wire [3:0] addr_f;
    wire [3:0] addr_g;
    reg [1:0] rd_word;
    reg wr_f_nxt;
    reg wr_g_nxt;
    reg wr_data_f_nxt;
    reg wr_data_g_nxt;
    wire wdata_hit;
    wire wr_mapped;

    // Match on the word index so the two low address bits never matter.
    function reg_hit;
        input [31:0] addr;
        input [31:0] offset;
        begin
            reg_hit = (addr[31:2] == offset[31:2]);
        end
    endfunction

    // Edge mode always strobes; level mode copies the strobe bit given.
    function strobe_on;
        input level;
        input strobe_bit;
        begin
            strobe_on = ~level | strobe_bit;
        end
    endfunction

    assign org = ctrl_r[`LDRAM_CTRL_ORG_LSB +: 2];
    // A single mode bit feeds both tables, so they cannot disagree.
    assign level_mode = ctrl_r[`LDRAM_CTRL_LEVEL_BIT];
    assign clk_neg = ctrl_r[`LDRAM_CTRL_EDGE_BIT];
    // Readies drop while a word is held or an answer waits: one at a time.
    assign awready = ~aw_have_r & ~bvalid;
    assign wready = ~w_have_r & ~bvalid;
    assign arready = ~rvalid;
    assign do_write = aw_have_r & w_have_r & ~bvalid;
    assign wdata_hit = do_write & reg_hit(awaddr_r, `LDRAM_ADDR_WDATA);
    assign wr_mapped = wdata_hit | reg_hit(awaddr_r, `LDRAM_ADDR_CTRL) |
        reg_hit(awaddr_r, `LDRAM_ADDR_ADDR);

    // Single port: read and write share the address field.
    assign addr_f = addr_r[3:0];
    // In dual 16x1 the G table may take an address of its own.
    assign addr_g = (org == `LDRAM_ORG_DUAL16) ? addr_r[11:8] : addr_r[3:0];

    // Table F; in dual-port mode its second read port is port B.
    ldram_table u_f (
        .aclk(aclk),
        .clk_neg(clk_neg),
        .level_mode(level_mode),
        .wr_en(wr_f_r),
        .wr_addr(addr_f),
        .wr_data(wr_data_f_r),
        .rd_addr_a(addr_f),
        .rd_addr_b(addr_r[19:16]),
        .rd_data_a(rd_f_a),
        .rd_data_b(rd_f_b)
    );

    // Table G; left idle in dual-port mode, where F serves both ports.
    ldram_table u_g (
        .aclk(aclk),
        .clk_neg(clk_neg),
        .level_mode(level_mode),
        .wr_en(wr_g_r),
        .wr_addr(addr_g),
        .wr_data(wr_data_g_r),
        .rd_addr_a(addr_g),
        .rd_addr_b(addr_r[19:16]),
        .rd_data_a(rd_g_a),
        .rd_data_b(rd_g_b)
    );

    // Read data select; the organisation picks which table outputs form the read word.
    always @* begin
        rd_word = 2'h0;
        case (org)
            `LDRAM_ORG_DUAL16: begin
                rd_word = {rd_g_a, rd_f_a};
            end
            `LDRAM_ORG_WIDE32: begin
                rd_word = {1'b0, addr_r[4] ? rd_g_a : rd_f_a};
            end
            `LDRAM_ORG_DPORT: begin
                rd_word = {rd_f_b, rd_f_a};
            end
            default: begin
                rd_word = {1'b0, rd_f_a};
            end
        endcase
    end

    // Next strobe state; edge mode drops a strobe after its one cycle.
    always @* begin
        wr_f_nxt = wr_f_r & level_mode;
        wr_g_nxt = wr_g_r & level_mode;
        wr_data_f_nxt = wr_data_f_r;
        wr_data_g_nxt = wr_data_g_r;
        if (wdata_hit) begin
            wr_data_f_nxt = wdata_r[0];
            wr_data_g_nxt = wdata_r[0];
            case (org)
                `LDRAM_ORG_DUAL16: begin
                    wr_data_g_nxt = wdata_r[1];
                    wr_f_nxt = strobe_on(level_mode, wdata_r[8]);
                    wr_g_nxt = strobe_on(level_mode, wdata_r[8]);
                end
                `LDRAM_ORG_WIDE32: begin
                    wr_f_nxt = strobe_on(level_mode, wdata_r[8]) & ~addr_r[4];
                    wr_g_nxt = strobe_on(level_mode, wdata_r[8]) & addr_r[4];
                end
                default: begin
                    wr_f_nxt = strobe_on(level_mode, wdata_r[8]);
                    wr_g_nxt = 1'b0;
                end
            endcase
        end
    end

    // Address and data are taken in either order and held until used.
    always @(posedge aclk) begin
        if (!aresetn) begin
            awaddr_r <= 32'h00000000;
            aw_have_r <= 1'b0;
            wdata_r <= 32'h00000000;
            w_have_r <= 1'b0;
        end else begin
            if (awvalid & awready) begin
                awaddr_r <= awaddr;
                aw_have_r <= 1'b1;
            end
            if (wvalid & wready) begin
                wdata_r <= wdata;
                w_have_r <= 1'b1;
            end
            if (do_write) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
            end
        end
    end

    // The write answer stands until the master takes it.
    always @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= 2'h0;
        end else if (do_write) begin
            bvalid <= 1'b1;
            if (wr_mapped) begin
                bresp <= `LDRAM_RESP_OKAY;
            end else begin
                bresp <= `LDRAM_RESP_SLVERR;
            end
        end else if (bvalid & bready) begin
            bvalid <= 1'b0;
        end
    end

    // Control and address registers.
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= `LDRAM_CTRL_RESET;
            func_r <= 16'h0000;
            addr_r <= 32'h00000000;
        end else if (do_write) begin
            if (reg_hit(awaddr_r, `LDRAM_ADDR_CTRL)) begin
                ctrl_r <= {28'h0000000, wdata_r[3:0]};
                func_r <= wdata_r[31:16];
            end else if (reg_hit(awaddr_r, `LDRAM_ADDR_ADDR)) begin
                addr_r <= wdata_r & 32'h000F0F1F;
            end
        end
    end

    // Strobes live in registers; level mode keeps them until rewritten.
    always @(posedge aclk) begin
        if (!aresetn) begin
            wr_f_r <= 1'b0;
            wr_g_r <= 1'b0;
            wr_data_f_r <= 1'b0;
            wr_data_g_r <= 1'b0;
        end else begin
            wr_f_r <= wr_f_nxt;
            wr_g_r <= wr_g_nxt;
            wr_data_f_r <= wr_data_f_nxt;
            wr_data_g_r <= wr_data_g_nxt;
        end
    end

    // Read channel; an unmapped word answers with an error and zero data.
    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rresp <= 2'h0;
            rdata <= 32'h00000000;
        end else if (arvalid & arready) begin
            rvalid <= 1'b1;
            rresp <= `LDRAM_RESP_OKAY;
            if (reg_hit(araddr, `LDRAM_ADDR_CTRL)) begin
                rdata <= {func_r, 12'h000, ctrl_r[3:0]};
            end else if (reg_hit(araddr, `LDRAM_ADDR_STATUS)) begin
                rdata <= {30'h00000000, wr_g_r, wr_f_r};
            end else if (reg_hit(araddr, `LDRAM_ADDR_ADDR)) begin
                rdata <= addr_r;
            end else if (reg_hit(araddr, `LDRAM_ADDR_RDATA)) begin
                rdata <= {30'h00000000, rd_word};
            end else begin
                rdata <= 32'h00000000;
                rresp <= `LDRAM_RESP_SLVERR;
            end
        end else if (rvalid & rready) begin
            rvalid <= 1'b0;
        end
    end

    // Leftover generators serve a five-input function in mixed mode.
    always @(posedge aclk) begin
        if (!aresetn) begin
            logic_out <= 1'b0;
        end else if (org == `LDRAM_ORG_MIXED) begin
            logic_out <= func_r[logic_in[3:0]] ^ logic_in[4];
        end else begin
            logic_out <= 1'b0;
        end
    end
endmodule

// ===== ldram_top_asserts.sv
`timescale 1ns/1ps
`include "ldram_regs.vh"
module ldram_top_asserts (
    input wire aclk,
    input wire aresetn,
    input wire awready,
    input wire wready,
    input wire [1:0] bresp,
    input wire bvalid,
    input wire bready,
    input wire [31:0] araddr,
    input wire arvalid,
    input wire arready,
    input wire [31:0] rdata,
    input wire [1:0] rresp,
    input wire rvalid,
    input wire rready
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_take;
        arvalid && arready;
    endsequence
    sequence s_bad;
        arvalid && arready && araddr == 32'h00000014;
    endsequence
    chk_rd_answer: assert property (s_take |=> rvalid)
        else $error("read answer late");
    chk_rd_stand: assert property
        (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data moved");
    chk_rd_block: assert property (rvalid |-> !arready)
        else $error("read taken while busy");
    chk_rd_unmap: assert property
        (s_bad |=> rresp == 2'h2 && rdata == 0)
        else $error("unmapped read not refused");
    chk_rd_done: assert property (rvalid && rready |=> !rvalid)
        else $error("read answer repeated");
    chk_wr_stand: assert property
        (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer moved");
    chk_wr_block: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while busy");
    chk_wr_done: assert property (bvalid && bready |=> !bvalid)
        else $error("write answer repeated");
endmodule
bind ldram_top ldram_top_asserts u_chk (.*);

// ===== ldram_user.sv
`timescale 1ns/1ps
module ldram_user (
    input wire aclk,
    input wire [4:0] pat,
    output reg [4:0] logic_in
);
    // Array logic feeding the five function inputs, one register deep.
    initial logic_in = 5'h00;
    always @(posedge aclk) begin
        logic_in <= pat;
    end
endmodule

// ===== tb.sv
`timescale 1ns/1ps
`include "ldram_regs.vh"
module tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [3:0] wstrb = 4'hF;
    logic [4:0] pat = 5'h00;
    wire awready, wready, bvalid, arready, rvalid, logic_out;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [4:0] logic_in;
    int fail_count = 0, check_count = 0, cyc = 0;
    logic [31:0] d, m;
    logic [1:0] r;
    logic [15:0] fv = 16'hA5C3;
    // Columns: control, address, write data, write wanted, read result.
    logic [31:0] tv [10][5] = '{
        '{32'h0, 32'h00903, 32'h2, 32'h1, 32'h2},
        '{32'h0, 32'h00309, 32'h1, 32'h1, 32'h1},
        '{32'h1, 32'h00005, 32'h1, 32'h1, 32'h1},
        '{32'h1, 32'h00015, 32'h0, 32'h1, 32'h0},
        '{32'h1, 32'h00005, 32'h0, 32'h0, 32'h1},
        '{32'h2, 32'h70007, 32'h1, 32'h1, 32'h3},
        '{32'h2, 32'h70005, 32'h0, 32'h1, 32'h2},
        '{32'h4, 32'h00C0C, 32'h103, 32'h1, 32'h3},
        '{32'h4, 32'h00C0C, 32'h0, 32'h1, 32'h3},
        '{32'h3, 32'h0000A, 32'h1, 32'h1, 32'h1}};
    ldram_top u_dut (.*);
    ldram_user u_user (.*);
    initial forever #12.5 aclk = ~aclk;
    task close_out;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Ready is sampled mid-cycle, so the release lands just after its edge.
    task wr(input logic [31:0] a, input logic [31:0] v);
        logic da, dw, ga, gw;
        da = 1'b0;
        dw = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(da && dw)) begin
            @(negedge aclk);
            ga = awvalid && awready;
            gw = wvalid && wready;
            @(posedge aclk);
            if (ga) awvalid <= 1'b0;
            if (gw) wvalid <= 1'b0;
            da = da || ga;
            dw = dw || gw;
        end
        do @(negedge aclk); while (!bvalid);
        r = bresp;
        @(posedge aclk);
        bready <= 1'b1;
        @(posedge aclk);
        bready <= 1'b0;
    endtask
    task rd(input logic [31:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(negedge aclk); while (!arready);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (!rvalid);
        d = rdata;
        r = rresp;
        @(posedge aclk);
        rready <= 1'b1;
        @(posedge aclk);
        rready <= 1'b0;
    endtask
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            close_out;
        end
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk({bvalid, rvalid, logic_out}, 32'h0);
        rd(`LDRAM_ADDR_CTRL);
        chk(d, `LDRAM_CTRL_RESET);
        for (int i = 0; i < 10; i++) begin
            wr(`LDRAM_ADDR_CTRL, tv[i][0]);
            wr(`LDRAM_ADDR_ADDR, tv[i][1]);
            if (tv[i][3][0]) wr(`LDRAM_ADDR_WDATA, tv[i][2]);
            if (tv[i][2][8]) wr(`LDRAM_ADDR_WDATA, tv[i][2] & 32'hFF);
            rd(`LDRAM_ADDR_RDATA);
            m = (tv[i][0][1:0] == 2'h1) ? 32'h1 : 32'h3;
            chk(d & m, tv[i][4]);
        end
        rd(32'h00000014);
        chk({30'h0, r}, {30'h0, `LDRAM_RESP_SLVERR});
        chk(d, 32'h0);
        wr(32'h00000014, 32'h0);
        chk({30'h0, r}, {30'h0, `LDRAM_RESP_SLVERR});
        wr(`LDRAM_ADDR_CTRL, 32'h4);
        chk({30'h0, r}, {30'h0, `LDRAM_RESP_OKAY});
        wr(`LDRAM_ADDR_WDATA, 32'h100);
        rd(`LDRAM_ADDR_STATUS);
        chk(d, 32'h3);
        wr(`LDRAM_ADDR_WDATA, 32'h0);
        rd(`LDRAM_ADDR_STATUS);
        chk(d, 32'h0);
        rd(`LDRAM_ADDR_RDATA);
        chk(d & 32'h3, 32'h0);
        wr(`LDRAM_ADDR_CTRL, 32'h0);
        wr(`LDRAM_ADDR_WDATA, 32'h3);
        rd(`LDRAM_ADDR_STATUS);
        chk(d, 32'h0);
        rd(`LDRAM_ADDR_RDATA);
        chk(d & 32'h3, 32'h3);
        wr(`LDRAM_ADDR_CTRL, {fv, 16'h0003});
        for (int i = 0; i < 32; i++) begin
            @(posedge aclk);
            pat <= i[4:0];
            repeat (3) @(posedge aclk);
            @(negedge aclk);
            chk({31'h0, logic_out}, {31'h0, fv[i[3:0]] ^ i[4]});
        end
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk({bvalid, rvalid, logic_out}, 32'h0);
        rd(`LDRAM_ADDR_CTRL);
        chk(d, `LDRAM_CTRL_RESET);
        rd(`LDRAM_ADDR_STATUS);
        chk(d, 32'h0);
        close_out;
    end
endmodule
